/* File: rtl/pra_top.sv */
`timescale 1ns/10ps
module pra_top
  import pra_pkg::*;
#(
  // Identification value is arbitrary
  parameter logic [31:0] SYS_ID = 32'h0000A5C3
) (
  // Clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // Instruction request
  input wire logic INSTR_VALID_I,
  output logic INSTR_READY_O,
  input wire logic [7:0] OPCODE_I,
  input wire logic [31:0] REGNUM_I,
  input wire logic [31:0] SRC_I,
  input wire logic [1:0] CUR_MODE_I,
  input wire logic CC_C_I,
  // Completion
  output logic DONE_O,
  output logic [31:0] DST_O,
  output logic RSVD_INSTR_FLT_O,
  output logic RSVD_OPND_FLT_O,
  output logic CC_N_O,
  output logic CC_Z_O,
  output logic CC_V_O,
  output logic CC_C_O,
  // Processor initialization
  input wire logic PER_PROCESS_SCOPE_INIT_I,
  output logic INIT_BUSY_O,
  // Context switch access
  input wire logic CTX_VALID_I,
  output logic CTX_READY_O,
  input wire logic CTX_WRITE_I,
  input wire logic [5:0] CTX_NUM_I,
  input wire logic [31:0] CTX_WDATA_I,
  output logic CTX_ACK_O,
  output logic CTX_ERR_O,
  output logic [31:0] CTX_RDATA_O,
  // Register side effects
  output logic REG_WR_O,
  output logic [5:0] REG_WR_NUM_O,
  output logic [31:0] REG_WR_DATA_O,
  output logic XLATE_INV_ALL_O,
  output logic XLATE_INV_ONE_O,
  output logic [15:1] SOFT_INT_PEND_O
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_READ = 2'b01,
    S_RESP = 2'b11,
    S_INIT = 2'b10
  } pra_state_t;

  pra_state_t state_r;
  pra_state_t state_nxt;
  logic [5:0] init_cnt_r;
  logic init_req_r;
  logic acc;
  logic is_wr;
  logic is_rd;
  logic [4:0] attr;
  logic [5:0] num;
  logic val_ok;
  logic f_instr;
  logic f_opnd;
  logic wr_ok;
  logic ctx_acc;
  logic ctx_ok;
  logic [4:0] ctx_attr;
  logic [4:0] init_attr;
  logic [31:0] init_val;
  logic is_rd_r;
  logic [5:0] num_r;
  logic [31:0] src_r;
  logic fi_r;
  logic fo_r;
  logic c_r;
  logic [31:0] rd_val;
  logic [31:0] xfer;
  logic [15:1] soft_interrupt_summary_r;
  logic ctx_ack_r;
  logic ctx_err_r;
  logic reg_wr_r;
  logic [5:0] reg_wr_num_r;
  logic [31:0] reg_wr_data_r;
  logic inv_all_r;
  logic inv_one_r;
  logic [31:0] dst_r;
  logic rif_r;
  logic rof_r;
  logic n_r;
  logic z_r;
  logic v_r;
  logic cc_r;

  pra_store_if #(.AW(6), .DW(32)) st ();

  pra_regstore #(.AW(6), .DW(32)) u_store (
    .clk_i(REF_CLK_I),
    .ce_i(CE_I),
    .st(st)
  );

  // Initialization waits for idle so an instruction is never cut short
  // A frozen block must not signal a take that it cannot perform
  assign INSTR_READY_O = CE_I && (state_r == S_IDLE) && !init_req_r;
  assign CTX_READY_O = INSTR_READY_O && !INSTR_VALID_I;
  assign INIT_BUSY_O = (state_r == S_INIT);
  assign DONE_O = (state_r == S_RESP);
  assign acc = INSTR_VALID_I && INSTR_READY_O;
  assign ctx_acc = CTX_VALID_I && CTX_READY_O;

  // Instruction decode and checks
  assign is_wr = (OPCODE_I == OPC_WRITE_REG);
  assign is_rd = (OPCODE_I == OPC_READ_REG);
  assign attr = reg_attr(REGNUM_I);
  assign num = REGNUM_I[5:0];

  always_comb
  begin
    val_ok = 1'b1;
    case (num)
      INTERRUPT_PRIORITY_LEVEL: val_ok = (SRC_I[31:IPL_VALUE_W] == '0);
      ASYNC_TRAP_LEVEL: val_ok = (SRC_I <= AST_MAX);
      SOFT_INTERRUPT_REQUEST:
        val_ok = (SRC_I[31:SOFT_INTERRUPT_REQUEST_VALUE_W] == '0) && (SRC_I[3:0] != 4'h0);
      MEMORY_MAPPING_ENABLE: val_ok = (SRC_I[31:1] == 31'h0);
      default: val_ok = 1'b1;
    endcase
  end

  // Mode check comes first; an unknown opcode is also refused
  assign f_instr = !(is_wr || is_rd) || (CUR_MODE_I != MODE_KERNEL);
  assign f_opnd = !f_instr && (!attr[A_EX]
    || (is_wr && !attr[A_WR]) || (is_rd && !attr[A_RD])
    || (is_wr && !val_ok));
  assign wr_ok = acc && is_wr && !f_instr && !f_opnd;

  assign ctx_attr = reg_attr({26'h0, CTX_NUM_I});
  assign ctx_ok = ctx_attr[A_PER_PROCESS_SCOPE];
  assign init_attr = reg_attr({26'h0, init_cnt_r});

  always_comb
  begin
    case (init_cnt_r)
      INTERRUPT_PRIORITY_LEVEL: init_val = IPL_PRESET;
      ASYNC_TRAP_LEVEL: init_val = AST_PRESET;
      default: init_val = 32'h00000000;
    endcase
  end

  // Store port: one writer per cycle
  always_comb
  begin
    st.we = 1'b0;
    st.waddr = num;
    st.wdata = SRC_I;
    if (state_r == S_INIT)
    begin
      st.we = init_attr[A_INIT];
      st.waddr = init_cnt_r;
      st.wdata = init_val;
    end
    else if (wr_ok)
    begin
      st.we = 1'b1;
    end
    else if (ctx_acc && CTX_WRITE_I && ctx_ok)
    begin
      st.we = 1'b1;
      st.waddr = CTX_NUM_I;
      st.wdata = CTX_WDATA_I;
    end
  end

  assign st.re = acc || (ctx_acc && !CTX_WRITE_I);
  assign st.raddr = acc ? num : CTX_NUM_I;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (init_req_r)
          state_nxt = S_INIT;
        else if (acc)
          state_nxt = S_READ;
      S_READ: state_nxt = S_RESP;
      S_RESP: state_nxt = S_IDLE;
      S_INIT:
        if (init_cnt_r == INIT_LAST)
          state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Reset runs the preset walk so flagged registers start defined
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      state_r <= S_INIT;
    else if (CE_I)
      state_r <= state_nxt;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      init_cnt_r <= INIT_FIRST;
    else if (CE_I)
    begin
      if (state_r == S_INIT)
        init_cnt_r <= init_cnt_r + 6'h01;
      else
        init_cnt_r <= INIT_FIRST;
    end
  end

  // A request during the walk is kept; the set wins over the clear
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      init_req_r <= 1'b0;
    else if (CE_I)
    begin
      if (PER_PROCESS_SCOPE_INIT_I)
        init_req_r <= 1'b1;
      else if (state_r == S_IDLE)
        init_req_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      is_rd_r <= 1'b0;
      num_r <= 6'h00;
      src_r <= 32'h00000000;
      fi_r <= 1'b0;
      fo_r <= 1'b0;
      c_r <= 1'b0;
    end
    else if (CE_I && acc)
    begin
      is_rd_r <= is_rd;
      num_r <= num;
      src_r <= SRC_I;
      fi_r <= f_instr;
      fo_r <= f_opnd;
      c_r <= CC_C_I;
    end
  end

  always_comb
  begin
    case (num_r)
      SOFT_INTERRUPT_SUMMARY: rd_val = {16'h0000, soft_interrupt_summary_r, 1'b0};
      SYSTEM_IDENTIFICATION: rd_val = SYS_ID;
      default: rd_val = st.rdata;
    endcase
  end

  assign xfer = is_rd_r ? rd_val : src_r;

  // Completion outputs; fault flags change on every move, condition codes only on a successful move
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      dst_r <= 32'h00000000;
      rif_r <= 1'b0;
      rof_r <= 1'b0;
      n_r <= 1'b0;
      z_r <= 1'b0;
      v_r <= 1'b0;
      cc_r <= 1'b0;
    end
    else if (CE_I && state_r == S_READ)
    begin
      rif_r <= fi_r;
      rof_r <= fo_r;
      if (!fi_r && !fo_r)
      begin
        dst_r <= xfer;
        n_r <= xfer[31];
        z_r <= (xfer == 32'h00000000);
        v_r <= 1'b0;
        cc_r <= c_r;
      end
    end
  end

  // Register-specific actions of a write
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      reg_wr_r <= 1'b0;
      reg_wr_num_r <= 6'h00;
      reg_wr_data_r <= 32'h00000000;
      inv_all_r <= 1'b0;
      inv_one_r <= 1'b0;
    end
    else if (CE_I)
    begin
      reg_wr_r <= wr_ok;
      inv_all_r <= wr_ok && (num == XLATE_INVALIDATE_ALL);
      inv_one_r <= wr_ok && (num == XLATE_INVALIDATE_SINGLE);
      if (wr_ok)
      begin
        reg_wr_num_r <= num;
        reg_wr_data_r <= SRC_I;
      end
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
      soft_interrupt_summary_r <= 15'h0000;
    else if (CE_I)
    begin
      if (state_r == S_INIT)
        soft_interrupt_summary_r <= 15'h0000;
      else if (wr_ok && num == SOFT_INTERRUPT_SUMMARY)
        soft_interrupt_summary_r <= SRC_I[15:1];
      else if (wr_ok && num == SOFT_INTERRUPT_REQUEST)
        soft_interrupt_summary_r[SRC_I[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      ctx_ack_r <= 1'b0;
      ctx_err_r <= 1'b0;
    end
    else if (CE_I)
    begin
      ctx_ack_r <= ctx_acc;
      ctx_err_r <= ctx_acc && !ctx_ok;
    end
  end

  assign DST_O = dst_r;
  assign RSVD_INSTR_FLT_O = rif_r;
  assign RSVD_OPND_FLT_O = rof_r;
  assign CC_N_O = n_r;
  assign CC_Z_O = z_r;
  assign CC_V_O = v_r;
  assign CC_C_O = cc_r;
  assign CTX_ACK_O = ctx_ack_r;
  assign CTX_ERR_O = ctx_err_r;
  assign CTX_RDATA_O = st.rdata;
  assign REG_WR_O = reg_wr_r;
  assign REG_WR_NUM_O = reg_wr_num_r;
  assign REG_WR_DATA_O = reg_wr_data_r;
  assign XLATE_INV_ALL_O = inv_all_r;
  assign XLATE_INV_ONE_O = inv_one_r;
  assign SOFT_INT_PEND_O = soft_interrupt_summary_r;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SRST_I || !CE_I);

  AST_USER_FAULT: assert property (
    acc && CUR_MODE_I != MODE_KERNEL |-> ##2 DONE_O && RSVD_INSTR_FLT_O)
    else $error("non-kernel move did not fault");
  AST_USER_NOWRITE: assert property (
    acc && CUR_MODE_I != MODE_KERNEL |-> !st.we ##1 !REG_WR_O)
    else $error("non-kernel move changed a register");
  AST_WR_STORE: assert property (
    wr_ok |-> st.we && st.waddr == REGNUM_I[5:0] && st.wdata == SRC_I)
    else $error("write move not stored");
  AST_RD_DONE: assert property (
    acc && is_rd && !f_instr && !f_opnd
      |-> ##1 DONE_O == 1'b0 ##1 DONE_O && !RSVD_OPND_FLT_O)
    else $error("read move not completed in two cycles");
  AST_HIGH_BITS: assert property (
    acc && !f_instr && REGNUM_I[31:6] != 26'h0 |-> ##2 RSVD_OPND_FLT_O)
    else $error("number above 63 accepted");
  AST_RO_WRITE: assert property (
    acc && is_wr && !f_instr && attr[A_EX] && !attr[A_WR]
      |-> !st.we ##2 RSVD_OPND_FLT_O)
    else $error("read-only register written");
  AST_WO_READ: assert property (
    acc && is_rd && !f_instr && attr[A_EX] && !attr[A_RD]
      |-> ##2 DONE_O && RSVD_OPND_FLT_O)
    else $error("write-only register read");
  AST_BAD_VALUE: assert property (
    acc && is_wr && !f_instr && !val_ok |-> !st.we ##2 RSVD_OPND_FLT_O)
    else $error("invalid value accepted");
  AST_SOFT_REQ: assert property (
    wr_ok && num == SOFT_INTERRUPT_REQUEST
      |=> SOFT_INT_PEND_O[$past(SRC_I[3:0])])
    else $error("soft request bit not set");
  AST_INIT_PRESET: assert property (
    state_r == S_INIT && init_cnt_r == INTERRUPT_PRIORITY_LEVEL
      |-> st.we && st.wdata == IPL_PRESET)
    else $error("preset not loaded");
  AST_CTX_SCOPE: assert property (
    ctx_acc && !ctx_ok |-> !st.we ##1 CTX_ACK_O && CTX_ERR_O)
    else $error("context access outside per-process scope");
  AST_FLAGS: assert property (
    $rose(DONE_O) && !RSVD_OPND_FLT_O && !RSVD_INSTR_FLT_O
      |-> !CC_V_O && CC_Z_O == (DST_O == 32'h0) && CC_N_O == DST_O[31])
    else $error("condition codes wrong");

  COV_WRITE: cover property (wr_ok ##2 DONE_O);
  COV_READ: cover property (acc && is_rd && !f_opnd && !f_instr ##2 DONE_O);
  COV_OPND_FAULT: cover property (DONE_O && RSVD_OPND_FLT_O);
  COV_INIT: cover property (PER_PROCESS_SCOPE_INIT_I ##[1:8] INIT_BUSY_O);

endmodule : pra_top

/* File: rtl/pra_pkg.sv */
package pra_pkg;

  // Instruction encodings
  localparam logic [7:0] OPC_WRITE_REG = 8'hDA;
  localparam logic [7:0] OPC_READ_REG = 8'hDB;
  localparam logic [1:0] MODE_KERNEL = 2'h0;

  // Register numbers never move once assigned
  localparam logic [5:0] KERNEL_STACK_POINTER = 6'h00,
    EXECUTIVE_STACK_POINTER = 6'h01, SUPERVISOR_STACK_POINTER = 6'h02,
    USER_STACK_POINTER = 6'h03, INTERRUPT_STACK_POINTER = 6'h04,
    REGION0_PAGE_TABLE_BASE = 6'h08, REGION0_PAGE_TABLE_LENGTH = 6'h09,
    REGION1_PAGE_TABLE_BASE = 6'h0A, REGION1_PAGE_TABLE_LENGTH = 6'h0B,
    SYSTEM_PAGE_TABLE_BASE = 6'h0C, SYSTEM_PAGE_TABLE_LENGTH = 6'h0D,
    PROCESS_CONTROL_BLOCK_BASE = 6'h10, SYSTEM_CONTROL_BLOCK_BASE = 6'h11,
    INTERRUPT_PRIORITY_LEVEL = 6'h12, ASYNC_TRAP_LEVEL = 6'h13,
    SOFT_INTERRUPT_REQUEST = 6'h14, SOFT_INTERRUPT_SUMMARY = 6'h15,
    INTERVAL_CLOCK_CONTROL = 6'h18, NEXT_INTERVAL_COUNT = 6'h19,
    INTERVAL_COUNT = 6'h1A, TIME_OF_YEAR = 6'h1B,
    CONSOLE_RX_CONTROL_STATUS = 6'h20, CONSOLE_RX_DATA = 6'h21,
    CONSOLE_TX_CONTROL_STATUS = 6'h22, CONSOLE_TX_DATA = 6'h23,
    ACCELERATOR_CONTROL_STATUS = 6'h28, ACCELERATOR_MAINTENANCE = 6'h29,
    WRITABLE_STORE_ADDRESS = 6'h2C, WRITABLE_STORE_DATA = 6'h2D,
    BACKPLANE_FAULT_STATUS = 6'h30, BACKPLANE_SILO = 6'h31,
    BACKPLANE_SILO_COMPARE = 6'h32, BACKPLANE_MAINTENANCE = 6'h33,
    BACKPLANE_ERROR = 6'h34, BACKPLANE_TIMEOUT_ADDRESS = 6'h35,
    BACKPLANE_QUADWORD_CLEAR = 6'h36, MEMORY_MAPPING_ENABLE = 6'h38,
    XLATE_INVALIDATE_ALL = 6'h39, XLATE_INVALIDATE_SINGLE = 6'h3A,
    MICROPROGRAM_BREAKPOINT = 6'h3C, PERF_MONITOR_ENABLE = 6'h3D,
    SYSTEM_IDENTIFICATION = 6'h3E;

  // Attribute bits: exists, readable, writable, per-process, preset
  localparam int A_EX = 4;
  localparam int A_RD = 3;
  localparam int A_WR = 2;
  localparam int A_PER_PROCESS_SCOPE = 1;
  localparam int A_INIT = 0;
  localparam logic [4:0] ATTR_NONE = 5'h00;
  localparam logic [4:0] ATTR_RW_PER_PROCESS_SCOPE = 5'h1E;
  localparam logic [4:0] ATTR_RW_PER_PROCESS_SCOPE_INIT = 5'h1F;
  localparam logic [4:0] ATTR_RW_CPU = 5'h1C;
  localparam logic [4:0] ATTR_RW_CPU_INIT = 5'h1D;
  localparam logic [4:0] ATTR_WO_CPU = 5'h14;
  localparam logic [4:0] ATTR_RO_CPU = 5'h18;

  // Presets and value limits
  localparam logic [31:0] IPL_PRESET = 32'h0000001F;
  localparam logic [31:0] AST_PRESET = 32'h00000004;
  localparam logic [31:0] AST_MAX = 32'h00000004;
  localparam int IPL_VALUE_W = 5;
  localparam int SOFT_INTERRUPT_REQUEST_VALUE_W = 4;
  localparam logic [5:0] INIT_LAST = 6'h3F;
  localparam logic [5:0] INIT_FIRST = 6'h00;

  function automatic logic [4:0] reg_attr(input logic [31:0] n);
    logic [4:0] a;
    a = ATTR_NONE;
    if (n[31:6] == 26'h0)
    begin
      case (n[5:0])
        KERNEL_STACK_POINTER, EXECUTIVE_STACK_POINTER,
        SUPERVISOR_STACK_POINTER, USER_STACK_POINTER,
        REGION0_PAGE_TABLE_BASE, REGION0_PAGE_TABLE_LENGTH,
        REGION1_PAGE_TABLE_BASE, REGION1_PAGE_TABLE_LENGTH,
        PROCESS_CONTROL_BLOCK_BASE: a = ATTR_RW_PER_PROCESS_SCOPE;
        ASYNC_TRAP_LEVEL, PERF_MONITOR_ENABLE: a = ATTR_RW_PER_PROCESS_SCOPE_INIT;
        INTERRUPT_STACK_POINTER, SYSTEM_PAGE_TABLE_BASE,
        SYSTEM_PAGE_TABLE_LENGTH, SYSTEM_CONTROL_BLOCK_BASE, TIME_OF_YEAR,
        ACCELERATOR_MAINTENANCE, WRITABLE_STORE_ADDRESS,
        MICROPROGRAM_BREAKPOINT: a = ATTR_RW_CPU;
        INTERRUPT_PRIORITY_LEVEL, SOFT_INTERRUPT_SUMMARY,
        INTERVAL_CLOCK_CONTROL, CONSOLE_RX_CONTROL_STATUS,
        CONSOLE_TX_CONTROL_STATUS, MEMORY_MAPPING_ENABLE,
        ACCELERATOR_CONTROL_STATUS, WRITABLE_STORE_DATA,
        BACKPLANE_FAULT_STATUS, BACKPLANE_SILO_COMPARE,
        BACKPLANE_MAINTENANCE, BACKPLANE_ERROR: a = ATTR_RW_CPU_INIT;
        SOFT_INTERRUPT_REQUEST, NEXT_INTERVAL_COUNT, CONSOLE_TX_DATA,
        XLATE_INVALIDATE_ALL, XLATE_INVALIDATE_SINGLE,
        BACKPLANE_QUADWORD_CLEAR: a = ATTR_WO_CPU;
        INTERVAL_COUNT, CONSOLE_RX_DATA, BACKPLANE_SILO,
        BACKPLANE_TIMEOUT_ADDRESS, SYSTEM_IDENTIFICATION: a = ATTR_RO_CPU;
        default: a = ATTR_NONE;
      endcase
    end
    return a;
  endfunction : reg_attr

endpackage : pra_pkg

/* File: rtl/pra_store_if.sv */
`timescale 1ns/10ps
interface pra_store_if #(parameter int AW = 6, parameter int DW = 32);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : pra_store_if

/* File: rtl/pra_regstore.sv */
`timescale 1ns/10ps
module pra_regstore #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input wire logic clk_i,
  input wire logic ce_i,
  pra_store_if.store st
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge clk_i)
  begin
    if (ce_i && st.we)
    begin
      mem[st.waddr] <= st.wdata;
    end
  end

  // Read data always leaves through a register
  always_ff @(posedge clk_i)
  begin
    if (ce_i && st.re)
    begin
      rdata_r <= mem[st.raddr];
    end
  end

  assign st.rdata = rdata_r;
endmodule : pra_regstore

/* File: bench/tb_processor_register_access.sv */
`timescale 1ns/10ps
module tb_processor_register_access;
  import pra_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] num;
    logic [31:0] src;
    logic [1:0] md;
    logic fi;
    logic fo;
    logic [31:0] d;
  } pra_row_t;
  // Arbitrary identification value
  localparam logic [31:0] ID_VAL = 32'h00005A17;
  localparam logic [7:0] WR = OPC_WRITE_REG;
  localparam logic [7:0] RD = OPC_READ_REG;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, iv = 1'b0, pinit = 1'b0;
  logic cv = 1'b0, cw = 1'b0, ccin = 1'b0, cexp;
  logic [7:0] op = 8'h00;
  logic [31:0] num = 32'h0, src = 32'h0, cwd = 32'h0, last_dst = 32'h0;
  logic [1:0] md = 2'h0;
  logic [5:0] cn = 6'h00;
  logic rdy, done, fi, fo, n, z, v, c, ibusy, crdy, cack, cerr;
  logic rwr, iall, ione, s_wr, s_all, s_one;
  logic [31:0] dst, crd, rdat;
  logic [5:0] rnum;
  logic [15:1] spend;
  int miscompares = 0, n_compared = 0;
  pra_row_t rows [0:23] = '{
    '{RD, 32'h12, 32'h0, 2'h0, 1'b0, 1'b0, 32'h1F},
    '{RD, 32'h13, 32'h0, 2'h0, 1'b0, 1'b0, 32'h4},
    '{RD, 32'h15, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
    '{WR, 32'h0, 32'h80000000, 2'h0, 1'b0, 1'b0, 32'h80000000},
    '{RD, 32'h0, 32'h0, 2'h0, 1'b0, 1'b0, 32'h80000000},
    '{WR, 32'h4, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
    '{RD, 32'h4, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
    '{WR, 32'h3E, 32'h1, 2'h0, 1'b0, 1'b1, 32'h0},
    '{WR, 32'h1A, 32'h1, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h14, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h23, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h80000000, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h100, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h5, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{RD, 32'h3E, 32'h0, 2'h0, 1'b0, 1'b0, ID_VAL},
    '{WR, 32'h12, 32'h20, 2'h0, 1'b0, 1'b1, 32'h0},
    '{WR, 32'h13, 32'h5, 2'h0, 1'b0, 1'b1, 32'h0},
    '{WR, 32'h14, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0},
    '{WR, 32'h38, 32'h2, 2'h0, 1'b0, 1'b1, 32'h0},
    '{WR, 32'h14, 32'h3, 2'h0, 1'b0, 1'b0, 32'h3},
    '{RD, 32'h15, 32'h0, 2'h0, 1'b0, 1'b0, 32'h8},
    '{WR, 32'h39, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0},
    '{WR, 32'h3A, 32'h1234, 2'h0, 1'b0, 1'b0, 32'h1234},
    '{8'hDC, 32'h0, 32'h0, 2'h0, 1'b1, 1'b0, 32'h0}
  };

  pra_top #(.SYS_ID(ID_VAL)) pra_top_i (
    .REF_CLK_I(clk), .SRST_I(srst), .CE_I(ce),
    .INSTR_VALID_I(iv), .INSTR_READY_O(rdy), .OPCODE_I(op),
    .REGNUM_I(num), .SRC_I(src), .CUR_MODE_I(md), .CC_C_I(ccin),
    .DONE_O(done), .DST_O(dst), .RSVD_INSTR_FLT_O(fi),
    .RSVD_OPND_FLT_O(fo), .CC_N_O(n), .CC_Z_O(z), .CC_V_O(v), .CC_C_O(c),
    .PER_PROCESS_SCOPE_INIT_I(pinit), .INIT_BUSY_O(ibusy),
    .CTX_VALID_I(cv), .CTX_READY_O(crdy), .CTX_WRITE_I(cw),
    .CTX_NUM_I(cn), .CTX_WDATA_I(cwd), .CTX_ACK_O(cack), .CTX_ERR_O(cerr),
    .CTX_RDATA_O(crd), .REG_WR_O(rwr), .REG_WR_NUM_O(rnum),
    .REG_WR_DATA_O(rdat), .XLATE_INV_ALL_O(iall), .XLATE_INV_ONE_O(ione),
    .SOFT_INT_PEND_O(spend)
  );

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check1(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask : check1

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Request held until the edge that samples ready high
  task automatic instr(input logic [7:0] o, input logic [31:0] nm,
                       input logic [31:0] sv, input logic [1:0] m);
    int k;
    s_wr = 1'b0;
    s_all = 1'b0;
    s_one = 1'b0;
    k = 0;
    @(posedge clk);
    op <= o;
    num <= nm;
    src <= sv;
    md <= m;
    iv <= 1'b1;
    ccin <= ~ccin;
    @(negedge clk);
    while (rdy !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cexp = ccin;
    iv <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      s_wr |= rwr;
      s_all |= iall;
      s_one |= ione;
      k++;
    end while (done !== 1'b1 && k < 6);
    check("latency", k, 32'd2);
  endtask : instr

  task automatic run_row(input pra_row_t r);
    logic ok;
    logic wok;
    logic [31:0] ed;
    instr(r.op, r.num, r.src, r.md);
    ok = !r.fi && !r.fo;
    wok = ok && r.op == WR;
    ed = ok ? r.d : last_dst;
    check1("instr fault", fi, r.fi);
    check1("operand fault", fo, r.fo);
    check("dst", dst, ed);
    check1("write pulse", s_wr, wok);
    check1("inv all", s_all, wok && r.num == 32'h39);
    check1("inv one", s_one, wok && r.num == 32'h3A);
    if (ok)
    begin
      check1("cc n", n, ed[31]);
      check1("cc z", z, ed == 32'h0);
      check1("cc v", v, 1'b0);
      check1("cc c", c, cexp);
      last_dst = ed;
    end
  endtask : run_row

  task automatic ctx(input logic w, input logic [5:0] nm,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cv <= 1'b1;
    cw <= w;
    cn <= nm;
    cwd <= d;
    @(negedge clk);
    while (crdy !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
  endtask : ctx

  task automatic init_walk;
    int k;
    k = 0;
    while (ibusy !== 1'b1 && k < 10)
    begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (ibusy === 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    check("preset walk", k, 32'd64);
  endtask : init_walk

  initial
  begin
    #50000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 24; i++)
      run_row(rows[i]);
    check1("soft pending", spend[3], 1'b1);
    check("inv address", rdat, 32'h1234);
    check("inv number", {26'h0, rnum}, 32'h3A);
    // Privilege beats every operand check and blocks the write
    run_row('{WR, 32'h0, 32'h5, 2'h1, 1'b1, 1'b0, 32'h0});
    run_row('{RD, 32'h80000000, 32'h0, 2'h3, 1'b1, 1'b0, 32'h0});
    run_row('{RD, 32'h0, 32'h0, 2'h0, 1'b0, 1'b0, 32'h80000000});
    run_row('{WR, 32'h2D, 32'h7FFFFFFF, 2'h0, 1'b0, 1'b0,
      32'h7FFFFFFF});
    run_row('{RD, 32'h2D, 32'h0, 2'h0, 1'b0, 1'b0, 32'h7FFFFFFF});
    // Context switch port
    ctx(1'b1, 6'h03, 32'h0000ABCD);
    check1("ctx ack", cack, 1'b1);
    check1("ctx err", cerr, 1'b0);
    ctx(1'b0, 6'h03, 32'h0);
    check("ctx rdata", crd, 32'h0000ABCD);
    run_row('{RD, 32'h3, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0000ABCD});
    ctx(1'b1, 6'h04, 32'h1);
    check1("ctx cpu err", cerr, 1'b1);
    run_row('{RD, 32'h4, 32'h0, 2'h0, 1'b0, 1'b0, 32'h0});
    // Initialization: presets return, unflagged registers keep contents
    run_row('{WR, 32'h1B, 32'hCAFE0001, 2'h0, 1'b0, 1'b0,
      32'hCAFE0001});
    run_row('{WR, 32'h12, 32'h3, 2'h0, 1'b0, 1'b0, 32'h3});
    @(posedge clk);
    pinit <= 1'b1;
    @(posedge clk);
    pinit <= 1'b0;
    @(negedge clk);
    init_walk();
    run_row('{RD, 32'h12, 32'h0, 2'h0, 1'b0, 1'b0, 32'h1F});
    run_row('{RD, 32'h1B, 32'h0, 2'h0, 1'b0, 1'b0, 32'hCAFE0001});
    // A frozen block takes no request and latches no initialization
    @(posedge clk);
    ce <= 1'b0;
    pinit <= 1'b1;
    @(posedge clk);
    pinit <= 1'b0;
    @(negedge clk);
    check1("frozen ready", rdy, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    check1("no init while frozen", ibusy, 1'b0);
    check1("ready after freeze", rdy, 1'b1);
    // Reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check1("ready in reset", rdy, 1'b0);
    check1("done in reset", done, 1'b0);
    @(posedge clk);
    srst <= 1'b0;
    last_dst = 32'h0;
    @(negedge clk);
    init_walk();
    run_row('{RD, 32'h13, 32'h0, 2'h0, 1'b0, 1'b0, 32'h4});
    report_and_stop();
  end
endmodule : tb_processor_register_access
